/* File: ptpb_builder.sv */
// patch thread payload builder with its register slave
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ptpb_builder #(
    parameter int MAX_ICP = 32,
    parameter int TAGS = 128
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic ICP_WE,
    input wire logic [4:0] ICP_IDX,
    input wire logic [15:0] ICP_HID,
    input wire logic [15:0] ICP_HND,
    input wire logic DISP_VALID,
    output logic DISP_READY,
    input wire logic [31:0] DISP_PRIM,
    input wire logic [15:0] DISP_PDR,
    input wire logic SRC_VALID,
    output logic SRC_READY,
    input wire logic [31:0] SRC_DATA,
    output logic PL_VALID,
    input wire logic PL_READY,
    output logic [31:0] PL_DATA,
    output logic PL_LAST,
    input wire logic THR_DONE,
    input wire logic [6:0] THR_TAG,
    input wire logic THR_DEREF,
    input wire logic [23:0] THR_TID,
    output logic DEREF_VALID,
    output logic [23:0] DEREF_TID,
    output logic ICP_RELEASE,
    output logic TE_ENABLE,
    output logic TE_SW_MODE
);
    import ptpb_pkg::*;

    logic [31:0] ctrl_reg, count_reg, const_reg, vtx_reg;
    logic [31:0] samp_reg, bind_reg, scr_reg, sema_reg;
    logic [31:0] icp_mem [MAX_ICP];
    logic [7:0] wadr_reg;
    logic wr_reg;
    logic [31:0] rdat_next;
    ptpb_state_e st_reg, st_next;
    logic [CNT_W-1:0] idx_reg;
    logic [6:0] inst_reg, tag_reg;
    logic [TID_W-1:0] tid_reg;
    logic [31:0] prim_reg;
    logic [15:0] pdr_reg;
    logic [31:0] hdr_dw, dw_next;
    logic pl_valid_reg, pl_last_reg;
    logic [31:0] pl_data_reg;
    ptpb_state_e pl_kind_reg;
    logic [2:0] pl_idx_reg;
    logic deref_reg, rel_reg;
    logic [23:0] deref_tid_reg;
    logic tag_avail;
    logic [6:0] tag_free;
    logic [TAG_W:0] tags_used;
    logic can, emit, sec_end, inst_end, take;
    logic [ICP_W-1:0] icp_cnt;
    logic [CNT_W-1:0] hnd_dw, cst_dw, vtx_dw, sec_len;
    logic [CLEN_W+1:0] cst_regs;
    logic incl;

    // slave never stalls, so status is always OKAY with no wait
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // address phase capture for writes
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            wr_reg <= 1'b0;
            wadr_reg <= '0;
        end else if (HREADY) begin
            wr_reg <= HSEL && HTRANS == HTRANS_NONSEQ && HWRITE;
            wadr_reg <= HADDR[7:0];
        end
    end

    // data phase register writes, unmapped addresses ignored
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            ctrl_reg <= RST_VAL;
            count_reg <= RST_VAL;
            const_reg <= RST_VAL;
            vtx_reg <= RST_VAL;
            samp_reg <= RST_VAL;
            bind_reg <= RST_VAL;
            scr_reg <= RST_VAL;
            sema_reg <= RST_VAL;
        end else if (wr_reg) begin
            unique case (wadr_reg)
                OFS_CTRL: ctrl_reg <= HWDATA;
                OFS_COUNT: count_reg <= HWDATA;
                OFS_CONST: const_reg <= HWDATA;
                OFS_VTX: vtx_reg <= HWDATA;
                OFS_SAMP: samp_reg <= HWDATA;
                OFS_BIND: bind_reg <= HWDATA;
                OFS_SCR: scr_reg <= HWDATA;
                OFS_SEMA: sema_reg <= HWDATA;
                default: ;
            endcase
        end
    end

    // read mux, data sampled at address phase for zero wait
    always_comb begin
        unique case (HADDR[7:0])
            OFS_CTRL: rdat_next = ctrl_reg;
            OFS_COUNT: rdat_next = count_reg;
            OFS_CONST: rdat_next = const_reg;
            OFS_VTX: rdat_next = vtx_reg;
            OFS_SAMP: rdat_next = samp_reg;
            OFS_BIND: rdat_next = bind_reg;
            OFS_SCR: rdat_next = scr_reg;
            OFS_SEMA: rdat_next = sema_reg;
            OFS_STAT: rdat_next = {tid_reg[TID_W-2:0], tags_used,
                st_reg != PTPB_IDLE};
            default: rdat_next = '0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST)
            HRDATA <= '0;
        else if (HREADY && HSEL && HTRANS == HTRANS_NONSEQ && !HWRITE)
            HRDATA <= rdat_next;
    end

    assign TE_ENABLE = ctrl_reg[CTRL_TEN];
    assign TE_SW_MODE = ctrl_reg[CTRL_SWT];

    // handle table, written by the fetch side before dispatch
    always_ff @(posedge MCLK) begin
        if (ICP_WE)
            icp_mem[ICP_IDX] <= {ICP_HID, ICP_HND};
    end

    // section lengths in dwords
    assign incl = ctrl_reg[CTRL_INCL];
    assign icp_cnt = count_reg[ICP_LSB +: ICP_W];
    // one register per eight points
    // widened first: a full 32-point count must not wrap to zero
    assign hnd_dw = incl
        ? (CNT_W'(icp_cnt) + CNT_W'(7)) >> REG_SH << REG_SH : '0;
    always_comb begin
        cst_regs = '0;
        for (int b = 0; b < NUM_CBUF; b++) begin
            if (const_reg[CEN_LSB + b])
                cst_regs = cst_regs + (CLEN_W + 2)'(
                    const_reg[b * CLEN_W +: CLEN_W]);
        end
    end
    assign cst_dw = CNT_W'(cst_regs) << REG_SH;
    assign vtx_dw = CNT_W'(icp_cnt) * CNT_W'(vtx_reg[7:0]);

    always_comb begin
        unique case (st_reg)
            PTPB_HDR: sec_len = CNT_W'(8);
            PTPB_HND: sec_len = hnd_dw;
            PTPB_CST: sec_len = cst_dw;
            PTPB_VTX: sec_len = vtx_dw;
            default: sec_len = '0;
        endcase
    end

    // output slot free, and which sections still move
    assign can = !pl_valid_reg || PL_READY;
    assign emit = can && (st_reg == PTPB_HDR || st_reg == PTPB_HND ||
        ((st_reg == PTPB_CST || st_reg == PTPB_VTX) && SRC_VALID));
    assign SRC_READY = can && (st_reg == PTPB_CST || st_reg == PTPB_VTX);
    assign sec_end = emit && idx_reg == sec_len - 1'b1;
    assign inst_end = inst_reg == count_reg[INST_LSB +: 7];
    assign take = st_reg == PTPB_ALLOC;
    assign DISP_READY = st_reg == PTPB_IDLE;

    ptpb_hdr_fmt u_hdr (
        .idx(idx_reg[2:0]),
        .pdr_handle(pdr_reg),
        .prim_id(prim_reg),
        .sema_reg(sema_reg),
        .inst_num(inst_reg),
        .samp_reg(samp_reg),
        .bind_reg(bind_reg),
        .scr_reg(scr_reg),
        .tag(tag_reg),
        .deref(incl && inst_end),
        .tid(tid_reg),
        .dw(hdr_dw)
    );

    ptpb_tag_alloc #(.TAGS(TAGS)) u_tag (
        .clk(MCLK),
        .rst(SYS_RST),
        .take(take),
        .give(THR_DONE),
        .give_tag(THR_TAG),
        .avail(tag_avail),
        .tag(tag_free),
        .used(tags_used)
    );

    always_comb begin
        unique case (st_reg)
            PTPB_HDR: dw_next = hdr_dw;
            PTPB_HND: dw_next = idx_reg < CNT_W'(icp_cnt)
                ? icp_mem[idx_reg[4:0]] : '0;
            default: dw_next = SRC_DATA;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        unique case (st_reg)
            PTPB_IDLE: if (DISP_VALID) st_next = PTPB_ALLOC;
            PTPB_ALLOC: if (tag_avail) st_next = PTPB_HDR;
            PTPB_HDR, PTPB_HND, PTPB_CST, PTPB_VTX: begin
                if (sec_end || sec_len == '0) begin
                    if (st_reg == PTPB_HDR && hnd_dw != '0)
                        st_next = PTPB_HND;
                    else if (st_reg < PTPB_CST && cst_dw != '0)
                        st_next = PTPB_CST;
                    else if (st_reg < PTPB_VTX && vtx_dw != '0)
                        st_next = PTPB_VTX;
                    else
                        st_next = inst_end ? PTPB_IDLE : PTPB_ALLOC;
                end
            end
            default: st_next = PTPB_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST)
            st_reg <= PTPB_IDLE;
        else
            st_reg <= st_next;
    end

    // dword index within a section
    always_ff @(posedge MCLK) begin
        if (SYS_RST || st_next != st_reg)
            idx_reg <= '0;
        else if (emit)
            idx_reg <= idx_reg + 1'b1;
    end

    // dispatch capture, instance and tag bookkeeping
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            prim_reg <= '0;
            pdr_reg <= '0;
            inst_reg <= '0;
            tag_reg <= '0;
            tid_reg <= '0;
        end else begin
            if (st_reg == PTPB_IDLE && DISP_VALID) begin
                prim_reg <= DISP_PRIM;
                pdr_reg <= DISP_PDR;
                inst_reg <= '0;
            end
            if (take && tag_avail) begin
                tag_reg <= tag_free;
                tid_reg <= tid_reg + 1'b1;
            end
            if (st_reg >= PTPB_HDR && st_next == PTPB_ALLOC)
                inst_reg <= inst_reg + 1'b1;
        end
    end

    // registered output stream, last marks the thread's final dword
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            pl_valid_reg <= 1'b0;
            pl_data_reg <= '0;
            pl_last_reg <= 1'b0;
            pl_kind_reg <= PTPB_IDLE;
            pl_idx_reg <= '0;
        end else if (can) begin
            pl_valid_reg <= emit;
            if (emit) begin
                pl_data_reg <= dw_next;
                pl_kind_reg <= st_reg;
                pl_idx_reg <= idx_reg[2:0];
                pl_last_reg <= sec_end &&
                    (st_next == PTPB_IDLE || st_next == PTPB_ALLOC);
            end
        end
    end
    assign PL_VALID = pl_valid_reg;
    assign PL_DATA = pl_data_reg;
    assign PL_LAST = pl_last_reg;

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            deref_reg <= 1'b0;
            deref_tid_reg <= '0;
        end else begin
            deref_reg <= THR_DONE && THR_DEREF;
            if (THR_DONE && THR_DEREF)
                deref_tid_reg <= THR_TID;
        end
    end
    assign DEREF_VALID = deref_reg;
    assign DEREF_TID = deref_tid_reg;

    always_ff @(posedge MCLK) begin
        if (SYS_RST)
            rel_reg <= 1'b0;
        else
            rel_reg <= !incl && st_reg >= PTPB_HDR &&
                st_next == PTPB_IDLE;
    end
    assign ICP_RELEASE = rel_reg;

    // header dword checks on the stream
    sequence hdr_at(int n);
        pl_valid_reg && pl_kind_reg == PTPB_HDR && pl_idx_reg == n;
    endsequence

    AST_HDR0_ZERO: assert property (@(posedge MCLK) disable iff (SYS_RST)
        hdr_at(0) |-> PL_DATA[31:16] == '0 && PL_DATA[15:0] == pdr_reg)
        else $error("dword zero wrong");
    AST_HDR1_PRIM: assert property (@(posedge MCLK) disable iff (SYS_RST)
        hdr_at(1) |-> PL_DATA == prim_reg)
        else $error("primitive number wrong");
    AST_HDR2_INST: assert property (@(posedge MCLK) disable iff (SYS_RST)
        hdr_at(2) |-> PL_DATA[22:16] == inst_reg && !PL_DATA[23])
        else $error("instance number wrong");
    AST_HDR4_RSV: assert property (@(posedge MCLK) disable iff (SYS_RST)
        hdr_at(4) |-> PL_DATA[4:0] == '0)
        else $error("binding low bits set");
    AST_HDR5_TAG: assert property (@(posedge MCLK) disable iff (SYS_RST)
        hdr_at(5) |-> PL_DATA[6:0] == tag_reg && PL_DATA[9:7] == '0)
        else $error("tag dword wrong");
    AST_HDR6_TID: assert property (@(posedge MCLK) disable iff (SYS_RST)
        hdr_at(6) |-> PL_DATA[23:0] == tid_reg && PL_DATA[30:24] == '0)
        else $error("thread number wrong");
    AST_HND_INCL: assert property (@(posedge MCLK) disable iff (SYS_RST)
        pl_valid_reg && pl_kind_reg == PTPB_HND |-> incl)
        else $error("handles without inclusion");

    sequence done_deref;
        THR_DONE && THR_DEREF;
    endsequence
    AST_DEREF_RET: assert property (@(posedge MCLK) disable iff (SYS_RST)
        done_deref |=> DEREF_VALID && DEREF_TID == $past(THR_TID))
        else $error("release not returned");
    AST_AUTO_REL: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !incl && st_reg >= PTPB_HDR && st_next == PTPB_IDLE
        |=> ICP_RELEASE ##1 !ICP_RELEASE)
        else $error("auto release missing");
    AST_HOLD: assert property (@(posedge MCLK) disable iff (SYS_RST)
        PL_VALID && !PL_READY |=> PL_VALID && $stable(PL_DATA))
        else $error("stream data changed under stall");
endmodule : ptpb_builder

/* File: ptpb_eu_model.sv */
// execution unit model: takes payload dwords and ends each thread
`timescale 1ns/1ps
module ptpb_eu_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic pl_valid,
    output logic pl_ready,
    input wire logic [31:0] pl_data,
    input wire logic pl_last,
    output logic thr_done,
    output logic [6:0] thr_tag,
    output logic thr_deref,
    output logic [23:0] thr_tid
);
    logic [31:0] g [0:127];
    int n = 0;
    int base = 0;
    // stall pattern comes from the bench so slow acceptance is exercised
    assign pl_ready = !stall;
    initial begin
        thr_done = 1'b0;
        thr_tag = 7'h00;
        thr_deref = 1'b0;
        thr_tid = 24'h000000;
    end
    always @(posedge clk) begin
        thr_done <= 1'b0;
        thr_tag <= ~thr_tag; // stale tag never looks valid
        if (pl_valid && pl_ready) begin
            g[n] <= pl_data;
            n <= n + 1;
        end
        if (pl_valid && pl_ready && pl_last) begin
            thr_done <= 1'b1;
            thr_tag <= g[base + 5][6:0];
            thr_deref <= g[base + 6][31];
            thr_tid <= g[base + 6][23:0];
            base <= n + 1;
        end
    end
endmodule : ptpb_eu_model

/* File: ptpb_hdr_fmt.sv */
// formats one header dword of the thread payload
`timescale 1ns/1ps
module ptpb_hdr_fmt (
    input wire logic [2:0] idx,
    input wire logic [15:0] pdr_handle,
    input wire logic [31:0] prim_id,
    input wire logic [31:0] sema_reg,
    input wire logic [6:0] inst_num,
    input wire logic [31:0] samp_reg,
    input wire logic [31:0] bind_reg,
    input wire logic [31:0] scr_reg,
    input wire logic [6:0] tag,
    input wire logic deref,
    input wire logic [23:0] tid,
    output logic [31:0] dw
);
    import ptpb_pkg::*;
    always_comb begin
        dw = '0;
        unique case (idx)
            3'h0: dw[HND_W-1:0] = pdr_handle;
            3'h1: dw = prim_id;
            3'h2: begin
                dw[31:SEMI_LSB] = sema_reg[31:SEMI_LSB];
                dw[22:INSTN_LSB] = inst_num;
                dw[15:BAR_LSB] = sema_reg[15:BAR_LSB];
                dw[SEMH_W-1:0] = sema_reg[SEMH_W-1:0];
            end
            3'h3: begin
                dw[31:PTR_LSB] = samp_reg[31:PTR_LSB];
                dw[SSZ_W-1:0] = scr_reg[SSZ_W-1:0];
            end
            3'h4: dw[31:PTR_LSB] = bind_reg[31:PTR_LSB];
            3'h5: begin
                dw[31:SCR_LSB] = scr_reg[31:SCR_LSB];
                dw[TAG_W-1:0] = tag;
            end
            3'h6: begin
                dw[DEREF_BIT] = deref;
                dw[TID_W-1:0] = tid;
            end
            3'h7: dw = '0;
        endcase
    end
endmodule : ptpb_hdr_fmt

/* File: ptpb_pkg.sv */
// constants, register map and types for the patch thread payload builder
//
// Overview of operation
// - control points go by value, by handle, or both in one payload
// - dword six bit 31 asks for handle release back to the stage
// - dword six bits 23:0 carry a unique hardware thread number
// - dword five bits 31:10 carry the 1KB aligned scratch offset
// - each thread gets a free seven bit tag, freed on completion
// - dword four bits 31:5 carry binding table offset, 4:0 zero
// - dword three bits 31:5 carry the sampler state table offset
// - four bit scratch size, 0 to 11, passed on as information
// - dword two bits 31:24 carry the semaphore dword index
// - dword two bits 22:16 carry the instance number of the patch
// - dword two carries the four bit barrier index
// - dword two bits 11:0 carry the semaphore handle software set
// - dword one carries the full 32 bit primitive number
// - dword zero bits 15:0 carry the record handle, 31:16 zero
// - first handle register only with handle inclusion enabled
// - more handle registers when control points exceed 8, 16, 24
// - pushed constants follow, summed enabled read lengths
// - pushed vertex data follows, dwords packed back to back
// - tessellation engine is fixed function and spawns no thread
// - software tessellation mode reads ready topologies instead
// - identical inputs give identical output in identical order
// - without handle inclusion handles are freed after last instance
package ptpb_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_CONST = 8'h08;
    localparam logic [7:0] OFS_VTX = 8'h0c;
    localparam logic [7:0] OFS_SAMP = 8'h10;
    localparam logic [7:0] OFS_BIND = 8'h14;
    localparam logic [7:0] OFS_SCR = 8'h18;
    localparam logic [7:0] OFS_SEMA = 8'h1c;
    localparam logic [7:0] OFS_STAT = 8'h20;
    localparam logic [31:0] RST_VAL = 32'h0000_0000;
    // control bits
    localparam int CTRL_INCL = 0;
    localparam int CTRL_SWT = 1;
    localparam int CTRL_TEN = 2;
    // count register fields, and the constant buffer enable bits of the constant register
    localparam int ICP_LSB = 0;
    localparam int INST_LSB = 8;
    localparam int CEN_LSB = 24;
    // payload field positions
    localparam int DEREF_BIT = 31;
    localparam int TID_W = 24;
    localparam int TAG_W = 7;
    localparam int SCR_LSB = 10;
    localparam int PTR_LSB = 5;
    localparam int SEMI_LSB = 24;
    localparam int INSTN_LSB = 16;
    localparam int BAR_LSB = 12;
    localparam int SEMH_W = 12;
    localparam int HND_W = 16;
    localparam int SSZ_W = 4;
    localparam int ICP_W = 6;
    localparam int CLEN_W = 6;
    localparam int NUM_CBUF = 4;
    localparam int REG_SH = 3;
    localparam int CNT_W = 14;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    typedef enum logic [2:0] {
        PTPB_IDLE = 3'b000,
        PTPB_ALLOC = 3'b001,
        PTPB_HDR = 3'b010,
        PTPB_HND = 3'b011,
        PTPB_CST = 3'b100,
        PTPB_VTX = 3'b101
    } ptpb_state_e;
endpackage : ptpb_pkg

/* File: ptpb_tag_alloc.sv */
// relative thread tag allocator with a free map
`timescale 1ns/1ps
module ptpb_tag_alloc #(
    parameter int TAGS = 128
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic take,
    input wire logic give,
    input wire logic [ptpb_pkg::TAG_W-1:0] give_tag,
    output logic avail,
    output logic [ptpb_pkg::TAG_W-1:0] tag,
    output logic [ptpb_pkg::TAG_W:0] used
);
    logic [TAGS-1:0] busy_reg;
    logic [ptpb_pkg::TAG_W:0] used_reg;

    // lowest free tag wins, so allocation order is repeatable
    always_comb begin
        avail = 1'b0;
        tag = '0;
        for (int i = TAGS - 1; i >= 0; i--) begin
            if (!busy_reg[i]) begin
                avail = 1'b1;
                tag = ptpb_pkg::TAG_W'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_reg <= '0;
        end else begin
            if (give)
                busy_reg[give_tag] <= 1'b0;
            if (take && avail)
                busy_reg[tag] <= 1'b1;
        end
    end

    // in-use count for status
    always_ff @(posedge clk) begin
        if (rst)
            used_reg <= '0;
        else if ((take && avail) && !(give && busy_reg[give_tag]))
            used_reg <= used_reg + 1'b1;
        else if (!(take && avail) && give && busy_reg[give_tag])
            used_reg <= used_reg - 1'b1;
    end
    assign used = used_reg;

    AST_TAG_FREE: assert property (@(posedge clk) disable iff (rst)
        take && avail |-> !busy_reg[tag])
        else $error("tag given while busy");
endmodule : ptpb_tag_alloc

/* File: testbench.sv */
// self-checking bench for the patch thread payload builder
`timescale 1ns/1ps
module testbench;
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic HSEL = 1'b0, HWRITE = 1'b0, ICP_WE = 1'b0;
    logic DISP_VALID = 1'b0, SRC_VALID = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0;
    logic [31:0] SRC_DATA = 32'h5000_0000;
    logic [1:0] HTRANS = 2'b00;
    logic [4:0] ICP_IDX = 5'h00;
    logic [15:0] ICP_HID = 16'h0000, ICP_HND = 16'h0000;
    logic [31:0] HRDATA, PL_DATA, rd_v;
    logic HREADYOUT, HRESP, DISP_READY, SRC_READY, PL_VALID, PL_READY;
    logic PL_LAST, THR_DONE, THR_DEREF, DEREF_VALID, ICP_RELEASE;
    logic TE_ENABLE, TE_SW_MODE;
    logic [6:0] THR_TAG;
    logic [23:0] THR_TID, DEREF_TID, der_tid;
    logic stall = 1'b0;
    int fails = 0, check_count = 0, cyc = 0, rel_n = 0, der_n = 0;

    ptpb_builder i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ICP_WE(ICP_WE),
        .ICP_IDX(ICP_IDX), .ICP_HID(ICP_HID), .ICP_HND(ICP_HND),
        .DISP_VALID(DISP_VALID), .DISP_READY(DISP_READY),
        .DISP_PRIM(32'h8765_4321), .DISP_PDR(16'h0abc),
        .SRC_VALID(SRC_VALID), .SRC_READY(SRC_READY), .SRC_DATA(SRC_DATA),
        .PL_VALID(PL_VALID), .PL_READY(PL_READY), .PL_DATA(PL_DATA),
        .PL_LAST(PL_LAST), .THR_DONE(THR_DONE), .THR_TAG(THR_TAG),
        .THR_DEREF(THR_DEREF), .THR_TID(THR_TID), .DEREF_VALID(DEREF_VALID),
        .DEREF_TID(DEREF_TID), .ICP_RELEASE(ICP_RELEASE),
        .TE_ENABLE(TE_ENABLE), .TE_SW_MODE(TE_SW_MODE));
    ptpb_eu_model i_eu (.clk(MCLK), .stall(stall), .pl_valid(PL_VALID),
        .pl_ready(PL_READY), .pl_data(PL_DATA), .pl_last(PL_LAST),
        .thr_done(THR_DONE), .thr_tag(THR_TAG), .thr_deref(THR_DEREF),
        .thr_tid(THR_TID));

    initial forever #4 MCLK = ~MCLK;
    // source stream, stall pattern and pulse counters
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        stall <= (cyc % 3 == 2);
        if (SRC_VALID && SRC_READY) SRC_DATA <= SRC_DATA + 32'h1;
        if (ICP_RELEASE === 1'b1) rel_n <= rel_n + 1;
        if (DEREF_VALID === 1'b1) begin
            der_n <= der_n + 1;
            der_tid <= DEREF_TID;
        end
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task final_report;
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // one edge, then bounded wait for hready
    task hw;
        int t;
        t = 0;
        @(posedge MCLK);
        while (HREADYOUT !== 1'b1 && t < 50) begin
            t++;
            @(posedge MCLK);
        end
        if (t >= 50) begin
            fails++;
            final_report;
        end
    endtask : hw
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= ptpb_pkg::HTRANS_NONSEQ;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        hw;
        HTRANS <= 2'b00;
        HSEL <= 1'b0;
        HWDATA <= d;
        hw;
        rd_v = HRDATA;
    endtask : ahb
    task waitb(input int k);
        for (int t = 0; t < 3000 && i_eu.base != k; t++) @(posedge MCLK);
        if (i_eu.base != k) begin
            fails++;
            final_report;
        end
    endtask : waitb
    task disp(input int k);
        chk("ready", DISP_READY, 32'h1);
        DISP_VALID <= 1'b1;
        @(posedge MCLK);
        DISP_VALID <= 1'b0;
        waitb(k);
        repeat (4) @(posedge MCLK);
    endtask : disp
    task hdr(input int o, input logic [6:0] ins, input logic dr);
        chk("dw0", i_eu.g[o], 32'h0000_0abc);
        chk("dw1", i_eu.g[o+1], 32'h8765_4321);
        chk("dw2", i_eu.g[o+2], {16'hab00 | ins, 16'h5123});
        chk("dw3", i_eu.g[o+3], 32'h1234_566b);
        chk("dw4", i_eu.g[o+4], 32'hdead_bee0);
        chk("dw5", i_eu.g[o+5] & 32'hffff_ff80, 32'h6c00);
        chk("dw6", i_eu.g[o+6][31:24], {dr, 7'h0});
        chk("dw7", i_eu.g[o+7], 32'h0);
    endtask : hdr
    task t_regs;
        ahb(1'b0, ptpb_pkg::OFS_CTRL, 32'h0);
        chk("ctrl", rd_v, ptpb_pkg::RST_VAL);
        ahb(1'b1, 8'h24, 32'hffff_ffff);
        ahb(1'b0, 8'h24, 32'h0);
        chk("unmapped", rd_v, 32'h0);
        ahb(1'b1, ptpb_pkg::OFS_CTRL, 32'h5);
        ahb(1'b1, ptpb_pkg::OFS_COUNT, 32'h109);
        ahb(1'b1, ptpb_pkg::OFS_CONST, 32'h0100_0001);
        ahb(1'b1, ptpb_pkg::OFS_VTX, 32'h1);
        ahb(1'b1, ptpb_pkg::OFS_SAMP, 32'h1234_567f);
        ahb(1'b1, ptpb_pkg::OFS_BIND, 32'hdead_beff);
        ahb(1'b1, ptpb_pkg::OFS_SCR, 32'h0000_6c0b);
        ahb(1'b1, ptpb_pkg::OFS_SEMA, 32'hab00_5123);
        ahb(1'b0, ptpb_pkg::OFS_COUNT, 32'h0);
        chk("count", rd_v, 32'h109);
        chk("te on", {TE_SW_MODE, TE_ENABLE}, 32'h1);
        for (int i = 0; i < 32; i++) begin
            ICP_WE <= 1'b1;
            ICP_IDX <= i[4:0];
            ICP_HID <= 16'h0100 + i[15:0];
            ICP_HND <= 16'h0200 + i[15:0];
            @(posedge MCLK);
        end
        ICP_WE <= 1'b0;
    endtask : t_regs
    // handles plus pushed data, two instances
    task t_patch;
        logic [31:0] e;
        disp(82);
        hdr(0, 7'd0, 1'b0);
        hdr(41, 7'd1, 1'b1);
        for (int i = 0; i < 2; i++) begin
            for (int k = 0; k < 16; k++) begin
                e = (k < 9) ? {16'h0100 + k[15:0], 16'h0200 + k[15:0]} : 0;
                chk("hnd", i_eu.g[41*i+8+k], e);
            end
            for (int j = 0; j < 17; j++) begin
                e = 32'h5000_0000 + 17 * i + j;
                chk("push", i_eu.g[41*i+24+j], e);
            end
        end
        chk("tid", i_eu.g[6][23:0] != i_eu.g[47][23:0], 32'h1);
        chk("tag", i_eu.g[5][6:0] != i_eu.g[46][6:0], 32'h1);
        chk("deref", der_n, 32'h1);
        chk("der id", der_tid, i_eu.g[47][23:0]);
        chk("rel", rel_n, 32'h0);
        ahb(1'b0, ptpb_pkg::OFS_STAT, 32'h0);
        chk("stat", rd_v[8:0], 32'h0);
    endtask : t_patch
    // header only, one instance, software mode
    task t_pass;
        ahb(1'b1, ptpb_pkg::OFS_CTRL, 32'h2);
        ahb(1'b1, ptpb_pkg::OFS_COUNT, 32'h20);
        ahb(1'b1, ptpb_pkg::OFS_CONST, 32'h0);
        ahb(1'b1, ptpb_pkg::OFS_VTX, 32'h0);
        disp(90);
        hdr(82, 7'd0, 1'b0);
        chk("sw", {TE_SW_MODE, TE_ENABLE}, 32'h2);
        chk("rel", rel_n, 32'h1);
        chk("deref", der_n, 32'h1);
    endtask : t_pass
    initial begin
        repeat (8) @(posedge MCLK);
        SYS_RST <= 1'b0;
        SRC_VALID <= 1'b1;
        t_regs;
        t_patch;
        t_pass;
        final_report;
    end
endmodule : testbench
